/* hw/clock_cfg_pkg.sv */
/*
 * Constants for the clock configuration register slice: serial
 * frame layout, register offsets, field positions, masks and resets.
 * Assumes 8-bit registers behind a 15-bit register address.
 */
package clock_cfg_pkg;
  // ----------------------------------------------------------------
  // serial frame
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int INSTR_BITS = 16;
  localparam int FRAME_BITS = 24;
  localparam int RW_BIT = 15;
  localparam logic [4:0] CNT_INSTR_DONE = 5'h10;
  localparam logic [4:0] CNT_LAST = 5'h17;
  localparam logic [4:0] CNT_FULL = 5'h18;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [14:0] OFF_DUTY = 15'h0082;
  localparam logic [14:0] OFF_CROSS = 15'h0083;
  localparam logic [14:0] OFF_REFCLK = 15'h0084;
  localparam logic [14:0] OFF_SYNC_HI = 15'h0088;
  localparam logic [14:0] OFF_SYNC_LO = 15'h0089;
  localparam logic [14:0] OFF_DLL_PWR = 15'h0090;
  localparam logic [14:0] OFF_DLL_CTRL = 15'h0091;

  // ----------------------------------------------------------------
  // writable bit masks; other bits are reserved
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_DUTY = 8'h1F;
  localparam logic [7:0] MASK_CROSS = 8'h8F;
  localparam logic [7:0] MASK_REFCLK = 8'h31;
  localparam logic [7:0] MASK_SYNC_HI = 8'h0F;
  localparam logic [7:0] MASK_SYNC_LO = 8'hFF;
  localparam logic [7:0] MASK_DLL_PWR = 8'h1F;
  localparam logic [7:0] MASK_DLL_CTRL = 8'hC0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_CROSS = 8'h80;
  localparam logic [7:0] RST_REFCLK = 8'h00;
  localparam logic [7:0] RST_SYNC_HI = 8'h00;
  localparam logic [7:0] RST_SYNC_LO = 8'h00;
  localparam logic [7:0] RST_DLL_PWR = 8'h1F;
  localparam logic [7:0] RST_DLL_CTRL = 8'hC0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DUTY_SIGN_BIT = 4;
  localparam int CROSS_EN_BIT = 7;
  localparam int REF_PD_BIT = 0;
  localparam int REF_RATE_LSB = 4;
  localparam int HYSTERESIS_ON_BIT = 3;
  localparam int RISE_BIT = 2;
  localparam int DELAY_LOOP_POWER_BIT = 0;
  localparam int COARSE_XC_BIT = 1;
  localparam int COARSE_DC_BIT = 2;
  localparam int FINE_XC_BIT = 3;
  localparam int FINE_DC_BIT = 4;
  localparam int TRACK_ERR_BIT = 7;
  localparam int SEARCH_ERR_BIT = 6;

  typedef enum logic [1:0] {
    RATE_1X = 2'h0,
    RATE_2X = 2'h1,
    RATE_4X = 2'h2,
    RATE_OFF = 2'h3
  } ref_rate_t;
endpackage

/* hw/reg_access_if.sv */
/*
 * Register access carrier between the serial port front end and the
 * register file. Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
interface reg_access_if;
  logic wr_pulse;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport front (output wr_pulse, output addr, output wdata,
                 input rdata);
  modport regs (input wr_pulse, input addr, input wdata,
                output rdata);
endinterface

/* hw/cfg_serial_port.sv */
/*
 * Configuration serial port front end: 16-bit instruction (read flag
 * then 15-bit address) followed by one data byte, MSB first.
 * Assumes sclk, sdi and cs_n are synchronous to clk_sys and slow.
 */
`timescale 1ns/1ns
module cfg_serial_port
  import clock_cfg_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic sclk, // serial clock, sampled
  input wire logic sdi, // serial data in
  input wire logic cs_n, // frame select, active low
  output logic sdo, // serial data out
  output logic sdo_oe_n, // sdo drive enable, active low
  reg_access_if.front bus // register access
);
  logic sclk_q;
  logic [4:0] cnt;
  logic [15:0] instr;
  logic [7:0] wr_sh;
  logic [7:0] rd_sh;
  logic wr_q;

  wire rise = !cs_n && sclk && !sclk_q;
  wire fall = !cs_n && !sclk && sclk_q;
  wire is_read = instr[RW_BIT];
  wire in_data = cnt >= CNT_INSTR_DONE;
  wire wr_go = rise && cnt == CNT_LAST && !is_read;

  assign bus.addr = instr[14:0];
  assign bus.wdata = wr_sh;
  assign bus.wr_pulse = wr_q;
  assign sdo = rd_sh[7];

  // ----------------------------------------------------------------
  // frame shifting
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      cnt <= 5'h00;
      instr <= 16'h0000;
      wr_sh <= 8'h00;
      wr_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      wr_q <= wr_go;
      if (cs_n) begin
        cnt <= 5'h00;
      end else if (rise && cnt != CNT_FULL) begin
        cnt <= cnt + 5'h01;
        if (!in_data) begin
          instr <= {instr[14:0], sdi};
        end else begin
          wr_sh <= {wr_sh[6:0], sdi};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read data out, launched on falling sclk
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_sh <= 8'h00;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= !(!cs_n && is_read && in_data && cnt != CNT_FULL);
      if (fall && is_read && in_data) begin
        if (cnt == CNT_INSTR_DONE) begin
          rd_sh <= bus.rdata;
        end else begin
          rd_sh <= {rd_sh[6:0], 1'b0};
        end
      end
    end
  end
endmodule

/* hw/dac_clock_config_regs.sv */
/*
 * Clock path configuration registers: duty offset, crossing point,
 * reference clock rate and power-down, sync receiver options and
 * delay-locked-loop enables and error policies.
 * Assumes software reaches it over the configuration serial port.
 */
//
// Contract
// [RULE1] The duty offset is a five-bit sign-magnitude code, sign on top, magnitude 0 to 15.
// [RULE2] Crossing control holds an enable at bit 7 resetting to one and a code in bits 3:0 resetting to zero.
// [RULE3] The reference rate field picks 1x, 2x, 4x or off for codes 00 to 11 and resets to 00.
// [RULE4] Reference control bit 0 powers the reference clock down when one and resets to zero.
// [RULE5] Sync control bit 3 turns receiver hysteresis on and resets to zero.
// [RULE6] Sync control bit 2 selects rising-edge sampling and resets to zero.
// [RULE7] The ten-bit hysteresis amount has bits 9:8 in the first sync register and 7:0 in the second.
// [RULE8] Loop power bit 0 powers down the loop, controller and digital clock and resets to one.
// [RULE9] Loop power bits 4 to 1 enable fine duty, fine cross, coarse duty and coarse cross, all resetting to one.
// [RULE10] Loop control bit 7 restarts on a tracking error when one and resets to one.
// [RULE11] Loop control bit 6 retries the search after an error when one and resets to one.
// [RULE12] Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
module dac_clock_config_regs
  import clock_cfg_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic sclk, // serial clock
  input wire logic sdi, // serial data in
  input wire logic cs_n, // serial frame select, active low
  output logic sdo, // serial data out
  output logic sdo_oe_n, // sdo drive enable, active low
  output logic duty_offset_negative, // duty offset sign
  output logic [3:0] duty_offset_magnitude, // duty offset size
  output logic crossing_adjust_on, // crossing adjust enable
  output logic [3:0] crossing_point_code, // crossing point
  output clock_cfg_pkg::ref_rate_t refclk_rate, // reference rate
  output logic refclk_gated, // rate code turns ref off
  output logic refclk_powerdown, // reference power-down
  output logic hysteresis_on, // sync hysteresis enable
  output logic sync_rising_edge_select, // sample on rising edge
  output logic [9:0] hysteresis_amount, // hysteresis amount
  output logic delay_loop_powerdown, // loop power-down
  output logic fine_line_duty_fix_on, // fine duty correction
  output logic fine_line_cross_on, // fine cross control
  output logic coarse_line_duty_fix_on, // coarse duty correction
  output logic coarse_line_cross_on, // coarse cross control
  output logic track_error_restart, // restart on track error
  output logic search_error_retry // retry on search error
);
  import clock_cfg_pkg::*;

  reg_access_if bus ();

  logic [7:0] duty_offset;
  logic [7:0] clock_crossing_control;
  logic [7:0] reference_clock_control;
  logic [7:0] sync_input_control_high;
  logic [7:0] sync_hysteresis_low;
  logic [7:0] delay_loop_power;
  logic [7:0] delay_loop_control;

  function automatic logic [7:0] masked(input logic [7:0] v,
                                        input logic [7:0] m);
    masked = v & m;
  endfunction

  // ----------------------------------------------------------------
  // serial port front end
  // ----------------------------------------------------------------
  cfg_serial_port u_port (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sclk(sclk),
    .sdi(sdi),
    .cs_n(cs_n),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .bus(bus.front)
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wr_duty = bus.wr_pulse && bus.addr == OFF_DUTY;
  wire wr_cross = bus.wr_pulse && bus.addr == OFF_CROSS;
  wire wr_ref = bus.wr_pulse && bus.addr == OFF_REFCLK;
  wire wr_sync_hi = bus.wr_pulse && bus.addr == OFF_SYNC_HI;
  wire wr_sync_lo = bus.wr_pulse && bus.addr == OFF_SYNC_LO;
  wire wr_pwr = bus.wr_pulse && bus.addr == OFF_DLL_PWR;
  wire wr_ctrl = bus.wr_pulse && bus.addr == OFF_DLL_CTRL;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_offset <= RST_DUTY; // [RULE1]
      clock_crossing_control <= RST_CROSS; // [RULE2]
      reference_clock_control <= RST_REFCLK; // [RULE3] [RULE4]
      sync_input_control_high <= RST_SYNC_HI; // [RULE5] [RULE6]
      sync_hysteresis_low <= RST_SYNC_LO; // [RULE7]
      delay_loop_power <= RST_DLL_PWR; // [RULE8] [RULE9]
      delay_loop_control <= RST_DLL_CTRL; // [RULE10] [RULE11]
    end else begin
      if (wr_duty) begin
        duty_offset <= masked(bus.wdata, MASK_DUTY); // [RULE12]
      end
      if (wr_cross) begin
        clock_crossing_control <= masked(bus.wdata, MASK_CROSS);
      end
      if (wr_ref) begin
        reference_clock_control <= masked(bus.wdata, MASK_REFCLK);
      end
      if (wr_sync_hi) begin
        sync_input_control_high <= masked(bus.wdata, MASK_SYNC_HI);
      end
      if (wr_sync_lo) begin
        sync_hysteresis_low <= masked(bus.wdata, MASK_SYNC_LO);
      end
      if (wr_pwr) begin
        delay_loop_power <= masked(bus.wdata, MASK_DLL_PWR);
      end
      if (wr_ctrl) begin
        delay_loop_control <= masked(bus.wdata, MASK_DLL_CTRL);
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    case (bus.addr)
      OFF_DUTY: bus.rdata = duty_offset;
      OFF_CROSS: bus.rdata = clock_crossing_control;
      OFF_REFCLK: bus.rdata = reference_clock_control;
      OFF_SYNC_HI: bus.rdata = sync_input_control_high;
      OFF_SYNC_LO: bus.rdata = sync_hysteresis_low;
      OFF_DLL_PWR: bus.rdata = delay_loop_power;
      OFF_DLL_CTRL: bus.rdata = delay_loop_control;
      default: bus.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign duty_offset_negative = duty_offset[DUTY_SIGN_BIT]; // [RULE1]
  assign duty_offset_magnitude = duty_offset[3:0]; // [RULE1]
  assign crossing_adjust_on = clock_crossing_control[CROSS_EN_BIT]; // [RULE2]
  assign crossing_point_code = clock_crossing_control[3:0]; // [RULE2]
  assign refclk_rate =
    ref_rate_t'(reference_clock_control[REF_RATE_LSB +: 2]); // [RULE3]
  assign refclk_gated = refclk_rate == RATE_OFF; // [RULE3]
  assign refclk_powerdown = reference_clock_control[REF_PD_BIT]; // [RULE4]
  assign hysteresis_on = sync_input_control_high[HYSTERESIS_ON_BIT]; // [RULE5]
  assign sync_rising_edge_select =
    sync_input_control_high[RISE_BIT]; // [RULE6]
  assign hysteresis_amount =
    {sync_input_control_high[1:0], sync_hysteresis_low}; // [RULE7]
  assign delay_loop_powerdown = delay_loop_power[DELAY_LOOP_POWER_BIT]; // [RULE8]
  assign fine_line_duty_fix_on = delay_loop_power[FINE_DC_BIT]; // [RULE9]
  assign fine_line_cross_on = delay_loop_power[FINE_XC_BIT]; // [RULE9]
  assign coarse_line_duty_fix_on =
    delay_loop_power[COARSE_DC_BIT]; // [RULE9]
  assign coarse_line_cross_on = delay_loop_power[COARSE_XC_BIT]; // [RULE9]
  assign track_error_restart =
    delay_loop_control[TRACK_ERR_BIT]; // [RULE10]
  assign search_error_retry =
    delay_loop_control[SEARCH_ERR_BIT]; // [RULE11]
endmodule

/* testbench/dac_clock_config_regs_props.sv */
/*
 * Checker for the clock configuration register slice.
 * Assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/1ns
module dac_clock_config_regs_props
  import clock_cfg_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic cs_n, // frame select
  input wire logic sdo_oe_n, // sdo enable
  input wire logic duty_offset_negative, // sign
  input wire logic [3:0] duty_offset_magnitude, // size
  input wire logic crossing_adjust_on, // enable
  input wire logic [3:0] crossing_point_code, // code
  input wire clock_cfg_pkg::ref_rate_t refclk_rate, // rate
  input wire logic refclk_gated, // rate off
  input wire logic refclk_powerdown, // ref down
  input wire logic hysteresis_on, // hysteresis
  input wire logic sync_rising_edge_select, // edge
  input wire logic [9:0] hysteresis_amount, // amount
  input wire logic delay_loop_powerdown, // loop down
  input wire logic fine_line_duty_fix_on, // fine duty
  input wire logic fine_line_cross_on, // fine cross
  input wire logic coarse_line_duty_fix_on, // coarse duty
  input wire logic coarse_line_cross_on, // coarse cross
  input wire logic track_error_restart, // track policy
  input wire logic search_error_retry // search policy
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_rate_gated: assert property (refclk_gated == (refclk_rate == RATE_OFF))
    else $error("gated flag does not follow rate code");
  a_duty_reset: assert property ($rose(rst_n) |->
    {duty_offset_negative, duty_offset_magnitude} == 5'h00)
    else $error("duty offset not at reset value");
  a_cross_reset: assert property ($rose(rst_n) |->
    crossing_adjust_on && crossing_point_code == 4'h0)
    else $error("crossing control not at reset value");
  a_ref_reset: assert property ($rose(rst_n) |->
    refclk_rate == RATE_1X && !refclk_powerdown)
    else $error("reference control not at reset value");
  a_sync_reset: assert property ($rose(rst_n) |-> !hysteresis_on &&
    !sync_rising_edge_select && hysteresis_amount == 10'h000)
    else $error("sync control not at reset value");
  a_loop_reset: assert property ($rose(rst_n) |-> {delay_loop_powerdown,
    fine_line_duty_fix_on, fine_line_cross_on, coarse_line_duty_fix_on,
    coarse_line_cross_on, track_error_restart, search_error_retry} == 7'h7F)
    else $error("loop controls not at reset value");
  a_fields_hold: assert property (cs_n [*4] |-> $stable({duty_offset_magnitude,
    crossing_point_code, refclk_rate, hysteresis_amount, delay_loop_powerdown,
    fine_line_cross_on, track_error_restart, search_error_retry}))
    else $error("field changed outside a frame");
  a_oe_idle: assert property (cs_n |=> sdo_oe_n)
    else $error("sdo driven outside a frame");
endmodule

bind dac_clock_config_regs dac_clock_config_regs_props
  dac_clock_config_regs_props_inst (.clk_sys, .rst_n, .cs_n, .sdo_oe_n,
  .duty_offset_negative, .duty_offset_magnitude, .crossing_adjust_on,
  .crossing_point_code, .refclk_rate, .refclk_gated, .refclk_powerdown,
  .hysteresis_on, .sync_rising_edge_select, .hysteresis_amount,
  .delay_loop_powerdown, .fine_line_duty_fix_on, .fine_line_cross_on,
  .coarse_line_duty_fix_on, .coarse_line_cross_on, .track_error_restart,
  .search_error_retry);

/* testbench/dac_clock_config_regs_tb.sv */
/*
 * Self-checking bench for the clock configuration register slice.
 * Assumes the serial frame of the design: read flag, address, byte.
 */
`timescale 1ns/1ns
module dac_clock_config_regs_tb;
  import clock_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic cs_n = 1'b1;
  logic sdo, sdo_oe_n, duty_offset_negative, crossing_adjust_on;
  logic refclk_gated, refclk_powerdown, hysteresis_on;
  logic sync_rising_edge_select, delay_loop_powerdown;
  logic fine_line_duty_fix_on, fine_line_cross_on, coarse_line_duty_fix_on;
  logic coarse_line_cross_on, track_error_restart, search_error_retry;
  logic [3:0] duty_offset_magnitude, crossing_point_code;
  logic [9:0] hysteresis_amount;
  ref_rate_t refclk_rate;
  logic [7:0] q;
  logic [32:0] fields;
  int bad_count = 0;
  int n_compared = 0;
  logic [14:0] offs [7] = '{15'h0082, 15'h0083, 15'h0084, 15'h0088,
    15'h0089, 15'h0090, 15'h0091};
  logic [7:0] rstv [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h1F, 8'hC0};
  logic [7:0] mskv [7] = '{8'h1F, 8'h8F, 8'h31, 8'h0F, 8'hFF, 8'h1F, 8'hC0};

  assign fields = {duty_offset_negative, duty_offset_magnitude,
    crossing_adjust_on, crossing_point_code, refclk_rate, refclk_gated,
    refclk_powerdown, hysteresis_on, sync_rising_edge_select,
    hysteresis_amount, delay_loop_powerdown, fine_line_duty_fix_on,
    fine_line_cross_on, coarse_line_duty_fix_on, coarse_line_cross_on,
    track_error_restart, search_error_retry};

  dac_clock_config_regs dac_clock_config_regs_inst (.clk_sys, .rst_n,
    .sclk, .sdi, .cs_n, .sdo, .sdo_oe_n, .duty_offset_negative,
    .duty_offset_magnitude, .crossing_adjust_on, .crossing_point_code,
    .refclk_rate, .refclk_gated, .refclk_powerdown, .hysteresis_on,
    .sync_rising_edge_select, .hysteresis_amount, .delay_loop_powerdown,
    .fine_line_duty_fix_on, .fine_line_cross_on, .coarse_line_duty_fix_on,
    .coarse_line_cross_on, .track_error_restart, .search_error_retry);

  always #10 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one frame; fewer than 24 bits aborts it
  task automatic xfer(input logic rd, input logic [14:0] a,
                      input logic [7:0] d, input int nbits,
                      output logic [7:0] r);
    logic [23:0] w;
    w = {rd, a, d};
    r = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      sdi = w[23 - i];
      wt(4);
      if (rd && i == 16) check("drive", 33'(sdo_oe_n), 33'h0);
      if (i >= 16) r = {r[6:0], sdo};
      sclk = 1'b1;
      wt(4);
    end
    sclk = 1'b0;
    wt(4);
    cs_n = 1'b1;
    sdi = 1'b0;
    wt(4);
    if (rd) check("release", 33'(sdo_oe_n), 33'h1);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end

  initial begin
    wt(10);
    rst_n = 1'b1;
    wt(3);
    check("fields", fields, 33'h00800007F);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, offs[i], 8'h00, 24, q);
      check("reset", 33'(q), 33'(rstv[i]));
    end
    for (int v = 0; v < 2; v++) begin
      for (int i = 0; i < 7; i++) begin
        xfer(1'b0, offs[i], v ? 8'h00 : 8'hFF, 24, q);
        xfer(1'b1, offs[i], 8'h00, 24, q);
        check("readback", 33'(q), 33'(v ? 8'h00 : mskv[i]));
      end
      check("fields", fields, v ? 33'h0 : 33'h1FFFFFFFF);
    end
    for (int c = 0; c < 4; c++) begin
      xfer(1'b0, OFF_REFCLK, {2'b11, 2'(c), 4'h1}, 24, q);
      check("rate", 33'({refclk_gated, refclk_powerdown, refclk_rate}),
            33'({c == 3, 1'b1, 2'(c)}));
    end
    xfer(1'b0, OFF_SYNC_HI, 8'hF6, 24, q);
    xfer(1'b0, OFF_SYNC_LO, 8'h5A, 24, q);
    check("sync", 33'({hysteresis_on, sync_rising_edge_select,
          hysteresis_amount}), 33'h25A | 33'h400);
    xfer(1'b0, OFF_DUTY, 8'hF7, 24, q);
    check("duty", 33'({duty_offset_negative, duty_offset_magnitude}),
          33'h17);
    xfer(1'b0, OFF_CROSS, 8'h8C, 20, q);
    check("abort", 33'({crossing_adjust_on, crossing_point_code}), 33'h0);
    xfer(1'b0, OFF_CROSS, 8'h85, 24, q);
    check("cross", 33'({crossing_adjust_on, crossing_point_code}), 33'h15);
    xfer(1'b0, 15'h0085, 8'hFF, 24, q);
    xfer(1'b1, 15'h0085, 8'h00, 24, q);
    check("unmapped", 33'(q), 33'h0);
    rst_n = 1'b0;
    wt(1);
    check("fields", fields, 33'h00800007F);
    wt(9);
    rst_n = 1'b1;
    wt(3);
    end_sim();
  end
endmodule
